/* hw/bdm_core.sv */
`timescale 1ns/1ps
`default_nettype none

// Function
// - Unused special addresses read as zero
// - Indirect ports access the pointed location
// - Pair zero bank 0; pair one selected bank
// - Pointer at port: read zero, write ignored
// - Direct accesses always reach bank 0
// - Bank select bit 0 chooses bank
// - Reset clears bank except idle watchdog reset
// - Special registers identical in both banks except 40H
// - Bank select upper seven bits read zero
// - Program counter low write jumps in page
// - Program counter jump adds one dummy cycle
// - Table read high byte into table register
// - Bit set or clear any location
// - Memory moves pass through the accumulator
// - Accumulator takes all ALU results
// - Pointers readable, writable, incrementable registers
// - EEPROM control only at 40H bank 1
// - Special registers low, general RAM above
module bdm_core (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire bdm_pkg::bdm_req_s req,
  output logic req_ready,
  output bdm_pkg::bdm_rsp_s rsp,
  input wire logic alu_we,
  input wire logic [7:0] alu_result,
  input wire logic [7:0] pc_low_now,
  output bdm_pkg::bdm_jump_s pc_jump,
  input wire logic core_rst,
  input wire logic wdt_idle_rst,
  input wire logic [7:0] ee_ctrl_rdata,
  output logic ee_ctrl_we,
  output logic [7:0] ee_ctrl_wdata,
  output logic [7:0] accumulator_reg,
  output logic [7:0] table_high_byte,
  output logic bank_select_bit
);

  typedef struct packed {
    bdm_pkg::bdm_state_e st;
    logic bank;
    logic [7:0] ptr0;
    logic [7:0] ptr1;
    logic [7:0] accum;
    logic [7:0] tbl_high;
    bdm_pkg::bdm_tgt_s tgt;
    bdm_pkg::bdm_op_e op;
    logic [2:0] bit_idx;
    logic [7:0] hold;
    logic done;
    logic [7:0] rdata;
    logic jump;
    logic [7:0] jump_low;
    logic dummy;
    logic ee_we;
    logic [7:0] ee_wdata;
  } bdm_core_s;

  bdm_core_s s_r;
  bdm_core_s s_nxt;
  bdm_pkg::bdm_tgt_s tgt;
  bdm_pkg::bdm_tgt_s wr_tgt;
  logic accept;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] rmw_val;
  logic ram_we;
  logic [bdm_pkg::RAM_AW-1:0] ram_waddr;
  logic [bdm_pkg::RAM_AW-1:0] ram_raddr;
  logic [7:0] ram_q;

  function automatic logic is_port(input logic [7:0] a);
    is_port = (a == bdm_pkg::ADDR_PORT_ZERO) || (a == bdm_pkg::ADDR_PORT_ONE);
  endfunction

  function automatic logic [bdm_pkg::RAM_AW-1:0] ram_index(
    input bdm_pkg::bdm_tgt_s t
  );
    ram_index = {t.bank, t.addr[5:0]};
  endfunction

  // Maps a bus address to the location really reached
  function automatic bdm_pkg::bdm_tgt_s resolve(
    input logic [7:0] a,
    input logic [7:0] p0,
    input logic [7:0] p1,
    input logic bk
  );
    bdm_pkg::bdm_tgt_s t;
    t.bank = 1'b0;
    t.addr = a;
    t.is_null = 1'b0;
    if (a == bdm_pkg::ADDR_PORT_ZERO)
    begin
      t.addr = p0;
    end
    else if (a == bdm_pkg::ADDR_PORT_ONE)
    begin
      t.addr = p1;
      t.bank = bk;
    end
    if (is_port(a) && is_port(t.addr))
    begin
      t.is_null = 1'b1;
    end
    t.is_ram = !t.is_null && (t.addr >= bdm_pkg::ADDR_GP_LO) &&
               (t.addr <= bdm_pkg::ADDR_GP_HI);
    t.is_ee_ctrl = !t.is_null && t.bank && (t.addr == bdm_pkg::ADDR_EE_CTRL);
    resolve = t;
  endfunction

  // Special register read; banks share one decode
  function automatic logic [7:0] sfr_read(
    input bdm_pkg::bdm_tgt_s t,
    input bdm_core_s s,
    input logic [7:0] pc_lo,
    input logic [7:0] ee
  );
    sfr_read = bdm_pkg::BYTE_ZERO;
    if (t.is_ee_ctrl)
    begin
      sfr_read = ee;
    end
    else if (!t.is_null && !t.is_ram)
    begin
      if (t.addr == bdm_pkg::ADDR_PTR_ZERO)
      begin
        sfr_read = s.ptr0;
      end
      else if (t.addr == bdm_pkg::ADDR_PTR_ONE)
      begin
        sfr_read = s.ptr1;
      end
      else if (t.addr == bdm_pkg::ADDR_BANK_SEL)
      begin
        sfr_read = {7'h00, s.bank};
      end
      else if (t.addr == bdm_pkg::ADDR_ACCUM)
      begin
        sfr_read = s.accum;
      end
      else if (t.addr == bdm_pkg::ADDR_PC_LOW)
      begin
        sfr_read = pc_lo;
      end
      else if (t.addr == bdm_pkg::ADDR_TBL_HIGH)
      begin
        sfr_read = s.tbl_high;
      end
      else
      begin
        sfr_read = bdm_pkg::BYTE_ZERO;
      end
    end
  endfunction

  assign req_ready = (s_r.st == bdm_pkg::ST_IDLE);
  assign accept = req.valid && req_ready;
  assign tgt = resolve(req.addr, s_r.ptr0, s_r.ptr1, s_r.bank);
  assign rmw_val = s_r.tgt.is_ram ? ram_q : s_r.hold;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.jump = 1'b0;
    s_nxt.ee_we = 1'b0;
    s_nxt.dummy = s_r.jump;
    wr_en = 1'b0;
    wr_data = s_r.accum;
    wr_tgt = tgt;
    ram_raddr = ram_index(tgt);
    ram_we = 1'b0;
    ram_waddr = ram_index(tgt);
    case (s_r.st)
      bdm_pkg::ST_IDLE:
      begin
        if (accept)
        begin
          s_nxt.tgt = tgt;
          s_nxt.op = req.op;
          s_nxt.bit_idx = req.bit_idx;
          s_nxt.hold = sfr_read(tgt, s_r, pc_low_now, ee_ctrl_rdata);
          if (req.op == bdm_pkg::OP_WRITE)
          begin
            wr_en = 1'b1;
            wr_data = s_r.accum;
            s_nxt.done = 1'b1;
            s_nxt.rdata = s_r.accum;
          end
          else if (req.op == bdm_pkg::OP_TBLRD)
          begin
            // low to target, high to table register
            wr_en = 1'b1;
            wr_data = req.tbl_word[7:0];
            s_nxt.tbl_high = req.tbl_word[15:8];
            s_nxt.done = 1'b1;
            s_nxt.rdata = req.tbl_word[7:0];
          end
          else
          begin
            s_nxt.st = bdm_pkg::ST_RMW;
          end
        end
      end
      bdm_pkg::ST_RMW:
      begin
        wr_tgt = s_r.tgt;
        ram_waddr = ram_index(s_r.tgt);
        s_nxt.st = bdm_pkg::ST_IDLE;
        s_nxt.done = 1'b1;
        s_nxt.rdata = rmw_val;
        case (s_r.op)
          bdm_pkg::OP_BSET:
          begin
            wr_en = 1'b1;
            wr_data = rmw_val | (bdm_pkg::BIT_ONE << s_r.bit_idx);
          end
          bdm_pkg::OP_BCLR:
          begin
            wr_en = 1'b1;
            wr_data = rmw_val & ~(bdm_pkg::BIT_ONE << s_r.bit_idx);
          end
          bdm_pkg::OP_INC:
          begin
            wr_en = 1'b1;
            wr_data = rmw_val + bdm_pkg::INC_STEP;
          end
          default:
          begin
            s_nxt.accum = rmw_val;
          end
        endcase
        s_nxt.rdata = wr_en ? wr_data : rmw_val;
      end
      default:
      begin
        s_nxt.st = bdm_pkg::ST_IDLE;
      end
    endcase
    // writes to a null target vanish
    if (wr_en && !wr_tgt.is_null)
    begin
      if (wr_tgt.is_ram)
      begin
        ram_we = 1'b1;
      end
      else if (wr_tgt.is_ee_ctrl)
      begin
        s_nxt.ee_we = 1'b1;
        s_nxt.ee_wdata = wr_data;
      end
      else if (wr_tgt.addr == bdm_pkg::ADDR_PTR_ZERO)
      begin
        s_nxt.ptr0 = wr_data;
      end
      else if (wr_tgt.addr == bdm_pkg::ADDR_PTR_ONE)
      begin
        s_nxt.ptr1 = wr_data;
      end
      else if (wr_tgt.addr == bdm_pkg::ADDR_BANK_SEL)
      begin
        s_nxt.bank = wr_data[bdm_pkg::BANK_SEL_BIT];
      end
      else if (wr_tgt.addr == bdm_pkg::ADDR_ACCUM)
      begin
        s_nxt.accum = wr_data;
      end
      else if (wr_tgt.addr == bdm_pkg::ADDR_PC_LOW)
      begin
        s_nxt.jump = 1'b1;
        s_nxt.jump_low = wr_data;
      end
      // table register and unused ignore writes
    end
    if (alu_we)
    begin
      s_nxt.accum = alu_result;
    end
    if (core_rst && !wdt_idle_rst)
    begin
      s_nxt.bank = bdm_pkg::BANK_RESET;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_r <= '0;
      s_r.st <= bdm_pkg::ST_IDLE;
      s_r.op <= bdm_pkg::OP_READ;
      s_r.bank <= bdm_pkg::BANK_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Synchronous read keeps RAM inference clean at one extra cycle
  bdm_ram u_ram (
    .clk_sys(clk_sys),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(wr_data),
    .raddr(ram_raddr),
    .rdata(ram_q)
  );

  assign rsp.done = s_r.done;
  assign rsp.rdata = s_r.rdata;
  assign pc_jump.jump = s_r.jump;
  assign pc_jump.low = s_r.jump_low;
  assign pc_jump.dummy = s_r.dummy;
  assign ee_ctrl_we = s_r.ee_we;
  assign ee_ctrl_wdata = s_r.ee_wdata;
  assign accumulator_reg = s_r.accum;
  assign table_high_byte = s_r.tbl_high;
  assign bank_select_bit = s_r.bank;

  a_direct_bank_zero: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    accept && !is_port(req.addr) |-> !tgt.bank && tgt.addr == req.addr)
    else $error("direct access left bank 0");

  a_port_zero_bank: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    accept && req.addr == bdm_pkg::ADDR_PORT_ZERO |-> !tgt.bank
      && tgt.addr == s_r.ptr0)
    else $error("first pair not in bank 0");

  a_null_reads_zero: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    accept && req.op == bdm_pkg::OP_READ && tgt.is_null
      |=> ##1 rsp.done && rsp.rdata == bdm_pkg::BYTE_ZERO)
    else $error("null indirect read not zero");

  a_bank_reset: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    core_rst && !wdt_idle_rst |=> !bank_select_bit)
    else $error("bank not cleared by reset");

  a_bank_wdt_keep: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    core_rst && wdt_idle_rst && !accept && s_r.st == bdm_pkg::ST_IDLE
      |=> $stable(bank_select_bit))
    else $error("watchdog idle reset moved bank");

  a_jump_dummy: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    pc_jump.jump |=> pc_jump.dummy && !pc_jump.jump ##1 !pc_jump.dummy)
    else $error("dummy cycle missing after jump");

  a_jump_low: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    accept && req.op == bdm_pkg::OP_WRITE && req.addr == bdm_pkg::ADDR_PC_LOW
      |=> pc_jump.jump && pc_jump.low == $past(accumulator_reg))
    else $error("low program counter write no jump");

  a_table_high: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    accept && req.op == bdm_pkg::OP_TBLRD
      |=> table_high_byte == $past(req.tbl_word[15:8]) && rsp.done)
    else $error("table high byte not captured");

  a_alu_acc: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    alu_we |=> accumulator_reg == $past(alu_result))
    else $error("ALU result lost");

  a_bp_upper_zero: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    accept && req.op == bdm_pkg::OP_READ && req.addr == bdm_pkg::ADDR_BANK_SEL
      && !alu_we ##1 !alu_we |=> accumulator_reg[7:1] == 7'h00)
    else $error("bank select upper bits not zero");

endmodule

`default_nettype wire

/* hw/bdm_pkg.sv */
package bdm_pkg;

  // Special function register map
  localparam logic [7:0] ADDR_PORT_ZERO = 8'h00;
  localparam logic [7:0] ADDR_PTR_ZERO = 8'h01;
  localparam logic [7:0] ADDR_PORT_ONE = 8'h02;
  localparam logic [7:0] ADDR_PTR_ONE = 8'h03;
  localparam logic [7:0] ADDR_BANK_SEL = 8'h04;
  localparam logic [7:0] ADDR_ACCUM = 8'h05;
  localparam logic [7:0] ADDR_PC_LOW = 8'h06;
  localparam logic [7:0] ADDR_TBL_HIGH = 8'h07;
  localparam logic [7:0] ADDR_EE_CTRL = 8'h40;
  localparam logic [7:0] ADDR_GP_LO = 8'h80;
  localparam logic [7:0] ADDR_GP_HI = 8'hbf;

  // Bank select field
  localparam int BANK_SEL_BIT = 0;
  localparam logic BANK_RESET = 1'b0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] INC_STEP = 8'h01;
  localparam logic [7:0] BIT_ONE = 8'h01;

  // General purpose RAM: two banks of 64 bytes
  localparam int RAM_AW = 7;
  localparam int RAM_DEPTH = 128;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RMW = 2'b10
  } bdm_state_e;

  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_BSET = 3'h2,
    OP_BCLR = 3'h3,
    OP_INC = 3'h4,
    OP_TBLRD = 3'h5
  } bdm_op_e;

  typedef struct packed {
    logic valid;
    bdm_op_e op;
    logic [7:0] addr;
    logic [2:0] bit_idx;
    logic [15:0] tbl_word;
  } bdm_req_s;

  typedef struct packed {
    logic done;
    logic [7:0] rdata;
  } bdm_rsp_s;

  typedef struct packed {
    logic jump;
    logic [7:0] low;
    logic dummy;
  } bdm_jump_s;

  typedef struct packed {
    logic is_ram;
    logic is_null;
    logic is_ee_ctrl;
    logic bank;
    logic [7:0] addr;
  } bdm_tgt_s;

endpackage

/* hw/bdm_ram.sv */
`timescale 1ns/1ps
`default_nettype none

module bdm_ram (
  input wire logic clk_sys,
  input wire logic we,
  input wire logic [bdm_pkg::RAM_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [bdm_pkg::RAM_AW-1:0] raddr,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:bdm_pkg::RAM_DEPTH-1];

  // No reset: contents are volatile and undefined at power up
  always_ff @(posedge clk_sys)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

`default_nettype wire

/* sim/banked_data_memory_addressing_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module banked_data_memory_addressing_tb;
  logic clk_sys;
  logic sys_rst;
  bdm_pkg::bdm_req_s req;
  bdm_pkg::bdm_rsp_s rsp;
  bdm_pkg::bdm_jump_s pc_jump;
  logic req_ready, alu_we, core_rst, wdt_idle_rst, ee_ctrl_we, bank_select_bit;
  logic [7:0] alu_result, pc_low_now, ee_ctrl_rdata, ee_ctrl_wdata;
  logic [7:0] accumulator_reg, table_high_byte, rd, ee_val, jump_low;
  logic ok, ee_seen, jumped, jump_prev, dummy_seen;
  int mismatches, num_checks, cycles;

  bdm_core i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req),
    .req_ready(req_ready), .rsp(rsp), .alu_we(alu_we),
    .alu_result(alu_result), .pc_low_now(pc_low_now), .pc_jump(pc_jump),
    .core_rst(core_rst), .wdt_idle_rst(wdt_idle_rst),
    .ee_ctrl_rdata(ee_ctrl_rdata), .ee_ctrl_we(ee_ctrl_we),
    .ee_ctrl_wdata(ee_ctrl_wdata),
    .accumulator_reg(accumulator_reg), .table_high_byte(table_high_byte),
    .bank_select_bit(bank_select_bit));

  bdm_core_model i_core (.clk_sys(clk_sys), .req_ready(req_ready),
    .rsp(rsp), .req(req), .alu_we(alu_we), .alu_result(alu_result),
    .pc_low_now(pc_low_now), .core_rst(core_rst),
    .wdt_idle_rst(wdt_idle_rst), .ee_ctrl_rdata(ee_ctrl_rdata));

  always #2 clk_sys = ~clk_sys;

  task give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Pulses are caught here, so no check races their single cycle
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (ee_ctrl_we === 1'b1)
    begin
      ee_seen <= 1'b1;
      ee_val <= ee_ctrl_wdata;
    end
    if (pc_jump.jump === 1'b1)
    begin
      jumped <= 1'b1;
      jump_low <= pc_jump.low;
    end
    if (jump_prev && pc_jump.dummy === 1'b1)
      dummy_seen <= 1'b1;
    jump_prev <= (pc_jump.jump === 1'b1);
    if (cycles == 3000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task go(input bdm_pkg::bdm_op_e o, input logic [7:0] a,
          input logic [2:0] b, input logic [15:0] w);
    i_core.issue(o, a, b, w, rd, ok);
    // A request that never completes is a failure too
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, ok, 1'b1);
    end
  endtask

  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    go(bdm_pkg::OP_READ, a, 3'h0, 16'h0000);
    chk(rd, exp);
  endtask

  // Stores go through the accumulator
  task put(input logic [7:0] a, input logic [7:0] v);
    i_core.alu_load(v);
    go(bdm_pkg::OP_WRITE, a, 3'h0, 16'h0000);
  endtask

  initial
  begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    {mismatches, num_checks, cycles} = '0;
    {ee_seen, jumped, jump_prev, dummy_seen} = 4'h0;
    {ee_val, jump_low} = 16'h0000;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1 chk({7'h00, bank_select_bit}, 8'h00);
    chk(accumulator_reg, 8'h00);
    rd_chk(bdm_pkg::ADDR_BANK_SEL, 8'h00);
    put(bdm_pkg::ADDR_BANK_SEL, 8'hff);
    rd_chk(bdm_pkg::ADDR_BANK_SEL, 8'h01);
    chk({7'h00, bank_select_bit}, 8'h01);
    put(8'h80, 8'h11);
    put(bdm_pkg::ADDR_PTR_ONE, 8'h80);
    put(bdm_pkg::ADDR_PORT_ONE, 8'h22);
    rd_chk(8'h80, 8'h11);
    rd_chk(bdm_pkg::ADDR_PORT_ONE, 8'h22);
    put(bdm_pkg::ADDR_PTR_ZERO, 8'h80);
    rd_chk(bdm_pkg::ADDR_PORT_ZERO, 8'h11);
    put(bdm_pkg::ADDR_PTR_ONE, bdm_pkg::ADDR_PTR_ZERO);
    rd_chk(bdm_pkg::ADDR_PORT_ONE, 8'h80);
    put(bdm_pkg::ADDR_PTR_ONE, bdm_pkg::ADDR_PORT_ZERO);
    put(bdm_pkg::ADDR_PORT_ONE, 8'h55);
    rd_chk(bdm_pkg::ADDR_PORT_ONE, 8'h00);
    rd_chk(bdm_pkg::ADDR_PORT_ZERO, 8'h11);
    put(8'h40, 8'h33);
    // The write strobe is caught one edge after the take
    @(posedge clk_sys);
    #1 chk({7'h00, ee_seen}, 8'h00);
    rd_chk(8'h40, 8'h00);
    put(bdm_pkg::ADDR_PTR_ONE, 8'h40);
    rd_chk(bdm_pkg::ADDR_PORT_ONE, 8'ha5);
    put(bdm_pkg::ADDR_PORT_ONE, 8'h0c);
    @(posedge clk_sys);
    #1 chk({7'h00, ee_seen}, 8'h01);
    chk(ee_val, 8'h0c);
    put(8'h20, 8'hc5);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'hc5, 8'h00);
    go(bdm_pkg::OP_TBLRD, 8'h81, 3'h0, 16'ha5c3);
    chk(table_high_byte, 8'ha5);
    rd_chk(8'h81, 8'hc3);
    chk(accumulator_reg, 8'hc3);
    go(bdm_pkg::OP_WRITE, 8'h83, 3'h0, 16'h0000);
    rd_chk(8'h83, 8'hc3);
    put(bdm_pkg::ADDR_TBL_HIGH, 8'h00);
    rd_chk(bdm_pkg::ADDR_TBL_HIGH, 8'ha5);
    rd_chk(bdm_pkg::ADDR_PC_LOW, 8'h5a);
    put(8'h82, 8'h0f);
    go(bdm_pkg::OP_BSET, 8'h82, 3'h7, 16'h0000);
    chk(rd, 8'h8f);
    go(bdm_pkg::OP_BCLR, 8'h82, 3'h0, 16'h0000);
    chk(rd, 8'h8e);
    rd_chk(8'h82, 8'h8e);
    put(bdm_pkg::ADDR_PTR_ZERO, 8'h84);
    go(bdm_pkg::OP_INC, bdm_pkg::ADDR_PTR_ZERO, 3'h0, 16'h0000);
    chk(rd, 8'h85);
    rd_chk(bdm_pkg::ADDR_PTR_ZERO, 8'h85);
    i_core.alu_load(8'h3c);
    #1 chk(accumulator_reg, 8'h3c);
    put(bdm_pkg::ADDR_PC_LOW, 8'h77);
    repeat (2) @(posedge clk_sys);
    #1 chk(jump_low, 8'h77);
    chk({7'h00, jumped}, 8'h01);
    chk({7'h00, dummy_seen}, 8'h01);
    i_core.cpu_reset(1'b1);
    #1 chk({7'h00, bank_select_bit}, 8'h01);
    i_core.cpu_reset(1'b0);
    #1 chk({7'h00, bank_select_bit}, 8'h00);
    put(bdm_pkg::ADDR_PTR_ONE, 8'hbf);
    put(bdm_pkg::ADDR_PORT_ONE, 8'h99);
    rd_chk(8'hbf, 8'h99);
    give_verdict();
  end
endmodule

`default_nettype wire

/* sim/bdm_core_model.sv */
`timescale 1ns/1ps
`default_nettype none

module bdm_core_model (
  input wire logic clk_sys,
  input wire logic req_ready,
  input wire bdm_pkg::bdm_rsp_s rsp,
  output bdm_pkg::bdm_req_s req,
  output logic alu_we,
  output logic [7:0] alu_result,
  output logic [7:0] pc_low_now,
  output logic core_rst,
  output logic wdt_idle_rst,
  output logic [7:0] ee_ctrl_rdata
);
  initial
  begin
    req = '0;
    alu_we = 1'b0;
    alu_result = 8'h00;
    pc_low_now = 8'h5a;
    core_rst = 1'b0;
    wdt_idle_rst = 1'b0;
    ee_ctrl_rdata = 8'ha5;
  end

  task alu_load(input logic [7:0] v);
    @(posedge clk_sys);
    alu_we <= 1'b1;
    alu_result <= v;
    @(posedge clk_sys);
    alu_we <= 1'b0;
    alu_result <= ~v;
  endtask

  task cpu_reset(input logic idle);
    @(posedge clk_sys);
    core_rst <= 1'b1;
    wdt_idle_rst <= idle;
    @(posedge clk_sys);
    core_rst <= 1'b0;
    wdt_idle_rst <= 1'b0;
  endtask

  // Only called while idle, so the second edge is the take
  task issue(input bdm_pkg::bdm_op_e op, input logic [7:0] addr,
             input logic [2:0] bit_idx, input logic [15:0] word,
             output logic [7:0] rdata, output logic ok);
    int n;
    @(posedge clk_sys);
    req <= '{valid: 1'b1, op: op, addr: addr, bit_idx: bit_idx,
             tbl_word: word};
    @(posedge clk_sys);
    // Released fields other than op do not keep the old value
    req <= '{valid: 1'b0, op: op, addr: ~addr, bit_idx: ~bit_idx,
             tbl_word: ~word};
    ok = 1'b0;
    rdata = 8'hxx;
    for (n = 0; n < 4 && !ok; n++)
    begin
      #1;
      if (rsp.done === 1'b1)
      begin
        rdata = rsp.rdata;
        ok = 1'b1;
      end
      else
        @(posedge clk_sys);
    end
  endtask
endmodule

`default_nettype wire
